/* hw/crs_pkg.sv */
/*
 * constants for the clock and reset sequencer: register map, field positions,
 * reset values and timing counts.
 * assumes a 10 MHz reference clock on pclk and a 32-bit APB register bus.
 */
package crs_pkg;
    // clock
    localparam int unsigned CLK_PERIOD_NS = 100;
    // sequence, in reference clock cycles
    localparam int unsigned SEQ_LEN       = 140;
    localparam int unsigned CLK_STAGE     = 20;
    localparam int unsigned FUNC_STAGE    = 80;
    localparam int unsigned FUNC_PULSE    = 16;
    localparam int unsigned CORE_PULSE    = 16;
    // pll lock waits, least waits rounded up
    localparam int unsigned LOCK_REG_US   = 400;
    localparam int unsigned LOCK_DITH_US  = 750;
    localparam int unsigned LOCK_REG_CYC  =
        (LOCK_REG_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned LOCK_DITH_CYC =
        (LOCK_DITH_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // widths
    localparam int unsigned NCORE  = 2;
    localparam int unsigned NDOM   = 4;
    localparam int unsigned NBR    = 4;
    localparam int unsigned CNT_W  = 8;
    localparam int unsigned LOCK_W = 13;
    localparam int unsigned PUL_W  = 5;
    // register offsets
    localparam logic [7:0] A_CTRL  = 8'h00;
    localparam logic [7:0] A_WDMSK = 8'h04;
    localparam logic [7:0] A_DOM   = 8'h08;
    localparam logic [7:0] A_BR    = 8'h0C;
    localparam logic [7:0] A_MODE  = 8'h10;
    localparam logic [7:0] A_STAT  = 8'h14;
    // control fields
    localparam int unsigned B_GSW  = 0;
    localparam int unsigned B_FSWP = 1;
    localparam int unsigned B_FSWS = 2;
    localparam int unsigned B_DBG  = 3;
    localparam int unsigned B_CDBG = 4;
    // mode fields
    localparam int unsigned B_L2A = 0;
    localparam int unsigned B_DDA = 1;
    localparam int unsigned B_DTH = 2;
    localparam int unsigned B_L2S = 3;
    localparam int unsigned B_AXS = 5;
    localparam int unsigned B_DDS = 7;
    localparam int unsigned B_RAT = 9;
    localparam int unsigned MODE_W = 12;
    // reset value of every register
    localparam logic [31:0] REG_RST = 32'h0000_0000;
    // pll source codes
    localparam logic [1:0] PLL0 = 2'h0;
    localparam logic [1:0] PLL3 = 2'h3;
endpackage

/* hw/crs_seq.sv */
/*
 * clock and reset sequencer: global reset sequence, watchdog and software
 * resets, debug resets, per-domain and per-branch resets, clock mode policy
 * and pll lock waits, with an APB register slave.
 * assumes every input is synchronous to pclk except the watchdog expiries.
 */
// Behaviour
// RL1: external reset pin low resets every flop at once, no synchroniser.
// RL2: reset sequence completes 140 reference clocks after reset release.
// RL3: release clocking logic first, then functional blocks, processor cluster last.
// RL4: board holds reset low at least 1000 reference clocks, 100 us minimum duration.
// RL5: unmasked global watchdog expiry, after sync, acts like external reset.
// RL6: a core watchdog expiry resets only that core.
// RL7: software can mask the global and each core watchdog.
// RL8: self-clearing global software reset acts exactly like external reset.
// RL9: functional reset spares plls, clock/reset logic and debug logic.
// RL10: functional reset exists as self-clearing pulse and as static hold.
// RL11: static debug bit holds all debug, trace and processor debug, in reset.
// RL12: separate bits reset processor debug logic on its own.
// RL13: all debug reset bits come out of reset inactive.
// RL14: each clock domain gets its own clock-synchronous reset.
// RL15: per-domain bit resets the whole domain with all branches.
// RL16: per-branch bit resets only that branch.
// RL17: sync mode: L2 and AXI from PLL0, ratios 1:1, 1:1.5, 1:n.
// RL18: async mode: L2 and AXI rates and sources fully independent.
// RL19: async DDR: DDR independent of AXI, dithering only from PLL3.
// RL20: sync DDR: DDR and AXI from PLL0 at 1:1, no dithering; code forces only ddr_src to PLL0, axi_src follows the L2-AXI mode.
// RL21: DDR mode choice independent of L2-AXI mode choice.
// RL22: wait 400 us for regular plls, 750 us for dithered pll.
// RL23: stage split set by constants; every release deasserts on the clock.
module crs_seq
    import crs_pkg::*;
#(
    parameter int unsigned LOCK_DITH = LOCK_DITH_CYC
) (
    // clock and reset
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    // apb slave
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [7:0]            paddr,
    input  wire logic [31:0]           pwdata,
    output      logic [31:0]           prdata,
    output      logic                  pready,
    output      logic                  pslverr,
    // watchdog expiries
    input  wire logic                  wd_glob_exp,
    input  wire logic [NCORE-1:0]      wd_core_exp,
    // reset outputs
    output      logic                  rst_clk_n,
    output      logic                  rst_func_n,
    output      logic                  rst_cpu_n,
    output      logic [NCORE-1:0]      rst_core_n,
    output      logic                  rst_dbg_n,
    output      logic [NCORE-1:0]      rst_cpu_dbg_n,
    output      logic [NDOM-1:0]       rst_dom_n,
    output      logic [NDOM*NBR-1:0]   rst_br_n,
    // clock policy
    output      logic [3:0]            pll_ok,
    output      logic                  clk_src_ok,
    output      logic                  l2_axi_async,
    output      logic                  ddr_async,
    output      logic                  ddr_dither,
    output      logic [1:0]            l2_src,
    output      logic [1:0]            axi_src,
    output      logic [1:0]            ddr_src,
    output      logic [2:0]            axi_ratio
);
    logic [NCORE:0]       wd_s1;
    logic [NCORE:0]       wd_s2;
    logic [NCORE:0]       wd_s3;
    logic [NCORE:0]       wd_rise;
    logic [NCORE:0]       wd_mask;
    logic                 wr;
    logic                 setup;
    logic                 gsw_hit;
    logic                 fswp_hit;
    logic                 hard_req;
    logic                 fsw_static;
    logic                 dbg_all;
    logic [NCORE-1:0]     cpu_dbg;
    logic [NDOM-1:0]      dom_bits;
    logic [NDOM*NBR-1:0]  br_bits;
    logic [MODE_W-1:0]    mode;
    logic [CNT_W-1:0]     seq_cnt;
    logic [CNT_W-1:0]     next_cnt;
    logic [LOCK_W-1:0]    lock_cnt;
    logic [PUL_W-1:0]     fcnt;
    logic [PUL_W-1:0]     ccnt [NCORE];
    logic                 func_act;
    logic                 clk_go;
    logic                 func_go;
    logic                 cpu_go;
    logic                 seq_done;
    logic [31:0]          rd_word;

    function automatic logic mapped(input logic [7:0] a);
        return (a[1:0] == 2'h0) && (a <= A_STAT);
    endfunction

    // sync mode forces the shared source
    function automatic logic [1:0] pick(input logic async_m, input logic [1:0] src);
        return async_m ? src : PLL0;
    endfunction

    // watchdog expiry synchronisers, edge taken after the second flop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wd_s1 <= '0;
            wd_s2 <= '0;
            wd_s3 <= '0;
        end else begin
            wd_s1 <= {wd_core_exp, wd_glob_exp};
            wd_s2 <= wd_s1;
            wd_s3 <= wd_s2;
        end
    end
    assign wd_rise = wd_s2 & ~wd_s3;

    assign setup    = psel & ~penable;
    assign wr       = psel & penable & pready & pwrite;
    assign gsw_hit  = wr && (paddr == A_CTRL) && pwdata[B_GSW];
    assign fswp_hit = wr && (paddr == A_CTRL) && pwdata[B_FSWP];
    assign hard_req = gsw_hit | (wd_rise[0] & ~wd_mask[0]); // [RL5] [RL7] [RL8]

    chk_wd_mask: assert property (@(posedge pclk) disable iff (!presetn)
        (wd_rise[0] && wd_mask[0] && !gsw_hit) |=> seq_cnt != '0) // [RL7]
        else $error("masked global watchdog caused a reset");

    // register file, cleared by every hard reset cause
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fsw_static <= REG_RST[B_FSWS];
            dbg_all    <= REG_RST[B_DBG]; // [RL13]
            cpu_dbg    <= REG_RST[B_CDBG +: NCORE]; // [RL13]
            wd_mask    <= REG_RST[NCORE:0];
            dom_bits   <= REG_RST[NDOM-1:0];
            br_bits    <= REG_RST[NDOM*NBR-1:0];
            mode       <= REG_RST[MODE_W-1:0];
        end else if (hard_req) begin
            fsw_static <= REG_RST[B_FSWS];
            dbg_all    <= REG_RST[B_DBG]; // [RL8] [RL13]
            cpu_dbg    <= REG_RST[B_CDBG +: NCORE];
            wd_mask    <= REG_RST[NCORE:0];
            dom_bits   <= REG_RST[NDOM-1:0];
            br_bits    <= REG_RST[NDOM*NBR-1:0];
            mode       <= REG_RST[MODE_W-1:0];
        end else if (wr) begin
            case (paddr)
                A_CTRL: begin
                    fsw_static <= pwdata[B_FSWS]; // [RL10]
                    dbg_all    <= pwdata[B_DBG]; // [RL11]
                    cpu_dbg    <= pwdata[B_CDBG +: NCORE]; // [RL12]
                end
                A_WDMSK: wd_mask  <= pwdata[NCORE:0]; // [RL7]
                A_DOM:   dom_bits <= pwdata[NDOM-1:0]; // [RL15]
                A_BR:    br_bits  <= pwdata[NDOM*NBR-1:0]; // [RL16]
                A_MODE:  mode     <= pwdata[MODE_W-1:0]; // [RL21]
                default: ;
            endcase
        end
    end

    chk_dbg_dflt: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(presetn) |-> !dbg_all && cpu_dbg == '0) // [RL13]
        else $error("debug reset bits not inactive after reset");

    // read mux
    always_comb begin
        rd_word = 32'h0000_0000;
        case (paddr)
            A_CTRL:  rd_word = {26'h0, cpu_dbg, dbg_all, fsw_static, 2'h0};
            A_WDMSK: rd_word = {29'h0, wd_mask};
            A_DOM:   rd_word = {28'h0, dom_bits};
            A_BR:    rd_word = {16'h0, br_bits};
            A_MODE:  rd_word = {20'h0, mode};
            A_STAT:  rd_word = {16'h0, ~rst_core_n, func_act, seq_done, pll_ok, seq_cnt};
            default: rd_word = 32'h0000_0000;
        endcase
    end

    // apb answer one cycle after setup
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= setup;
            pslverr <= setup & ~mapped(paddr);
            prdata  <= setup ? rd_word : 32'h0000_0000;
        end
    end

    chk_apb_ready: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && !penable) |=> pready ##1 !pready)
        else $error("apb answer not one cycle after setup");

    // reset sequence counter, restarted by every hard reset cause
    always_comb begin
        next_cnt = seq_cnt;
        if (hard_req) begin
            next_cnt = '0; // [RL5] [RL8]
        end else if (seq_cnt < CNT_W'(SEQ_LEN)) begin
            next_cnt = seq_cnt + 1'b1; // [RL2]
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            seq_cnt <= '0; // [RL1]
        end else begin
            seq_cnt <= next_cnt;
        end
    end

    assign clk_go   = next_cnt >= CNT_W'(CLK_STAGE); // [RL3] [RL23]
    assign func_go  = next_cnt >= CNT_W'(FUNC_STAGE); // [RL3] [RL23]
    assign cpu_go   = next_cnt >= CNT_W'(SEQ_LEN); // [RL2] [RL3]
    assign seq_done = seq_cnt >= CNT_W'(SEQ_LEN);

    chk_seq_end: assert property (@(posedge pclk) disable iff (!presetn)
        (seq_cnt == CNT_W'(SEQ_LEN - 1) && !hard_req) |=> seq_done && rst_clk_n) // [RL2]
        else $error("sequence did not complete at its last count");

    chk_cpu_late: assert property (@(posedge pclk) disable iff (!presetn)
        rst_cpu_n |-> seq_cnt >= CNT_W'(SEQ_LEN)) // [RL2]
        else $error("cluster released before the sequence ended");

    chk_stage_ord: assert property (@(posedge pclk) disable iff (!presetn)
        (rst_func_n |-> rst_clk_n) and (rst_cpu_n |-> rst_func_n)) // [RL3]
        else $error("stage released out of order");

    chk_hard_all: assert property (@(posedge pclk) disable iff (!presetn)
        hard_req |=> !rst_clk_n && !rst_cpu_n && !rst_dbg_n && seq_cnt == '0) // [RL5]
        else $error("hard reset did not restart the sequence");

    // functional reset pulse
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fcnt <= '0;
        end else if (hard_req) begin
            fcnt <= '0;
        end else if (fswp_hit) begin
            fcnt <= PUL_W'(FUNC_PULSE); // [RL10]
        end else if (fcnt != '0) begin
            fcnt <= fcnt - 1'b1;
        end
    end
    assign func_act = (fcnt != '0) | fsw_static; // [RL10]

    chk_func_pulse: assert property (@(posedge pclk) disable iff (!presetn)
        (fswp_hit && !hard_req && seq_done) |=> ##1 !rst_func_n [*8]) // [RL10]
        else $error("functional pulse too short");

    chk_func_keep: assert property (@(posedge pclk) disable iff (!presetn)
        (func_act && seq_done && !hard_req && !dbg_all) |=> rst_clk_n && rst_dbg_n
        && !rst_func_n) // [RL9]
        else $error("functional reset touched clock or debug logic");

    // per-core watchdog pulses
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int c = 0; c < NCORE; c++) begin
                ccnt[c] <= '0;
            end
        end else begin
            for (int c = 0; c < NCORE; c++) begin
                if (hard_req) begin
                    ccnt[c] <= '0;
                end else if (wd_rise[c+1] && !wd_mask[c+1]) begin
                    ccnt[c] <= PUL_W'(CORE_PULSE); // [RL6] [RL7]
                end else if (ccnt[c] != '0) begin
                    ccnt[c] <= ccnt[c] - 1'b1;
                end
            end
        end
    end

    // reset outputs, all released on a pclk edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rst_clk_n     <= 1'b0; // [RL1]
            rst_func_n    <= 1'b0;
            rst_cpu_n     <= 1'b0;
            rst_core_n    <= '0;
            rst_dbg_n     <= 1'b0;
            rst_cpu_dbg_n <= '0;
            rst_dom_n     <= '0;
            rst_br_n      <= '0;
        end else begin
            rst_clk_n  <= clk_go; // [RL14] [RL23]
            rst_func_n <= func_go & ~func_act; // [RL9]
            rst_cpu_n  <= cpu_go & ~func_act;
            rst_dbg_n  <= clk_go & ~dbg_all; // [RL11]
            for (int c = 0; c < NCORE; c++) begin
                rst_core_n[c]    <= cpu_go & ~func_act & (ccnt[c] == '0); // [RL6]
                rst_cpu_dbg_n[c] <= clk_go & ~dbg_all & ~cpu_dbg[c]; // [RL11] [RL12]
            end
            for (int d = 0; d < NDOM; d++) begin
                rst_dom_n[d] <= func_go & ~func_act & ~dom_bits[d]; // [RL14] [RL15]
                for (int b = 0; b < NBR; b++) begin
                    rst_br_n[d*NBR+b] <= func_go & ~func_act & ~dom_bits[d]
                        & ~br_bits[d*NBR+b]; // [RL15] [RL16]
                end
            end
        end
    end

    chk_core_only: assert property (@(posedge pclk) disable iff (!presetn)
        (wd_rise == 3'b010 && !wd_mask[1] && seq_done && !func_act) |=> ##1
        !rst_core_n[0] && rst_core_n[1] && rst_cpu_n) // [RL6]
        else $error("core watchdog reset spread beyond its core");

    chk_dbg_hold: assert property (@(posedge pclk) disable iff (!presetn)
        dbg_all |=> !rst_dbg_n && rst_cpu_dbg_n == '0) // [RL11]
        else $error("debug logic not held in reset");

    chk_branch: assert property (@(posedge pclk) disable iff (!presetn)
        (dom_bits[0] |=> rst_br_n[NBR-1:0] == '0 && !rst_dom_n[0])
        and ((br_bits[0] && !dom_bits[1]) |=> !rst_br_n[0])) // [RL15] [RL16]
        else $error("domain or branch reset not applied");

    // pll lock wait, counted from release of the clocking logic
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lock_cnt <= '0;
            pll_ok   <= '0;
        end else if (hard_req) begin
            lock_cnt <= '0;
            pll_ok   <= '0;
        end else begin
            if (rst_clk_n && lock_cnt != '1) begin
                lock_cnt <= lock_cnt + 1'b1;
            end
            pll_ok[2:0] <= {3{lock_cnt >= LOCK_W'(LOCK_REG_CYC)}}; // [RL22]
            pll_ok[3]   <= lock_cnt >= LOCK_W'(LOCK_DITH); // [RL22]
        end
    end

    chk_pll_wait: assert property (@(posedge pclk) disable iff (!presetn)
        (pll_ok[0] |-> lock_cnt >= LOCK_W'(LOCK_REG_CYC))
        and (pll_ok[3] |-> lock_cnt >= LOCK_W'(LOCK_DITH))) // [RL22]
        else $error("pll used before its lock time");

    // clock mode policy
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            l2_axi_async <= 1'b0;
            ddr_async    <= 1'b0;
            ddr_dither   <= 1'b0;
            l2_src       <= PLL0;
            axi_src      <= PLL0;
            ddr_src      <= PLL0;
            axi_ratio    <= '0;
            clk_src_ok   <= 1'b0;
        end else begin
            l2_axi_async <= mode[B_L2A]; // [RL18]
            ddr_async    <= mode[B_DDA]; // [RL21]
            ddr_dither   <= mode[B_DDA] & mode[B_DTH]; // [RL19] [RL20]
            l2_src       <= pick(mode[B_L2A], mode[B_L2S +: 2]); // [RL17] [RL18]
            axi_src      <= pick(mode[B_L2A], mode[B_AXS +: 2]); // [RL17]
            if (!mode[B_DDA]) begin
                ddr_src <= PLL0; // [RL20]
            end else if (mode[B_DTH]) begin
                ddr_src <= PLL3; // [RL19]
            end else begin
                ddr_src <= mode[B_DDS +: 2];
            end
            axi_ratio  <= mode[B_RAT +: 3]; // [RL17]
            clk_src_ok <= pll_ok[pick(mode[B_L2A], mode[B_L2S +: 2])]
                & pll_ok[pick(mode[B_L2A], mode[B_AXS +: 2])]
                & pll_ok[ddr_src]; // [RL22]
        end
    end

    chk_ddr_sync: assert property (@(posedge pclk) disable iff (!presetn)
        !mode[B_DDA] |=> ddr_src == PLL0 && !ddr_dither) // [RL20]
        else $error("sync ddr mode not on pll0 or dithering");

    chk_l2_sync: assert property (@(posedge pclk) disable iff (!presetn)
        !mode[B_L2A] |=> l2_src == PLL0 && axi_src == PLL0) // [RL17]
        else $error("sync l2 axi mode not on pll0");
endmodule

/* sim/crs_board.sv */
/*
 * board side model: reset supervisor driving the reset pin and the
 * watchdog expiry sources.
 * assumes requests from the bench that change just after a pclk edge.
 */
module crs_board #(
    parameter int unsigned MIN_LOW = 1000
) (
    // clock and bench requests
    input  wire logic       pclk,
    input  wire logic       rst_req,
    input  wire logic [2:0] wd_req,
    // pins toward the sequencer
    output      logic       presetn,
    output      logic       wd_glob_exp,
    output      logic [1:0] wd_core_exp
);
    timeunit 1ns;
    timeprecision 1ns;
    int unsigned low_cnt;
    initial begin
        presetn     = 1'b0;
        low_cnt     = 0;
        wd_glob_exp = 1'b0;
        wd_core_exp = 2'b00;
    end
    // reset pin held low for the minimum time after a request
    always @(posedge pclk) begin
        if (rst_req) begin
            presetn <= 1'b0;
            low_cnt <= 0;
        end else if (low_cnt + 1 < MIN_LOW) begin
            low_cnt <= low_cnt + 1;
        end else begin
            presetn <= 1'b1;
        end
    end
    // expiry levels follow the bench requests
    always @(posedge pclk) begin
        wd_glob_exp <= wd_req[0];
        wd_core_exp <= wd_req[2:1];
    end
endmodule

/* sim/tb_crs_seq.sv */
/*
 * testbench for the clock and reset sequencer: apb tasks, sequence timing,
 * software, watchdog, debug, domain and clock mode checks.
 * assumes the board model drives the reset pin and watchdog expiries.
 */
module tb_crs_seq
    import crs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int unsigned DITH = 50;
    localparam logic [31:0] MODE_WR  [4] = '{32'h0000_03CC, 32'h0000_03CD,
                                             32'h0000_06CE, 32'h0000_013B};
    localparam logic [31:0] MODE_EXP [4] = '{32'h0000_0200, 32'h0000_0249,
                                             32'h0000_0786, 32'h0000_013B};
    logic                pclk;
    logic                rst_req;
    logic [2:0]          wd_req;
    logic                presetn;
    logic                wd_glob_exp;
    logic [1:0]          wd_core_exp;
    logic                psel;
    logic                penable;
    logic                pwrite;
    logic [7:0]          paddr;
    logic [31:0]         pwdata;
    logic [31:0]         prdata;
    logic                pready;
    logic                pslverr;
    logic [31:0]         rd;
    logic                err;
    logic                rst_clk_n;
    logic                rst_func_n;
    logic                rst_cpu_n;
    logic [NCORE-1:0]    rst_core_n;
    logic                rst_dbg_n;
    logic [NCORE-1:0]    rst_cpu_dbg_n;
    logic [NDOM-1:0]     rst_dom_n;
    logic [NDOM*NBR-1:0] rst_br_n;
    logic [3:0]          pll_ok;
    logic                clk_src_ok;
    logic                l2_axi_async;
    logic                ddr_async;
    logic                ddr_dither;
    logic [1:0]          l2_src;
    logic [1:0]          axi_src;
    logic [1:0]          ddr_src;
    logic [2:0]          axi_ratio;
    int                  errors;
    int                  num_checks;
    int                  cyc;
    int                  g0;
    int                  n;

    crs_board u_crs_board (.pclk(pclk), .rst_req(rst_req), .wd_req(wd_req),
        .presetn(presetn), .wd_glob_exp(wd_glob_exp), .wd_core_exp(wd_core_exp));
    crs_seq #(.LOCK_DITH(DITH)) u_crs_seq (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .wd_glob_exp(wd_glob_exp),
        .wd_core_exp(wd_core_exp), .rst_clk_n(rst_clk_n), .rst_func_n(rst_func_n),
        .rst_cpu_n(rst_cpu_n), .rst_core_n(rst_core_n), .rst_dbg_n(rst_dbg_n),
        .rst_cpu_dbg_n(rst_cpu_dbg_n), .rst_dom_n(rst_dom_n), .rst_br_n(rst_br_n),
        .pll_ok(pll_ok), .clk_src_ok(clk_src_ok), .l2_axi_async(l2_axi_async),
        .ddr_async(ddr_async), .ddr_dither(ddr_dither), .l2_src(l2_src),
        .axi_src(axi_src), .ddr_src(ddr_src), .axi_ratio(axi_ratio));

    initial begin
        pclk = 1'b0;
        forever #(CLK_PERIOD_NS / 2) pclk = ~pclk;
    end

    task automatic end_sim();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // cycle ceiling against hangs
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            errors++;
            end_sim();
        end
    end

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // one apb transfer, entered in the time step of a rising edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd      = prdata;
        err     = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input string nm);
        apb(1'b0, a, 32'h0000_0000);
        check(nm, rd, exp);
    endtask

    // write, then let the registered outputs land
    task automatic wrs(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
        repeat (1) @(posedge pclk);
    endtask

    task automatic wait_low();
        n = 0;
        while (rst_clk_n !== 1'b0 && n < 10) begin
            @(posedge pclk);
            n++;
        end
        check("reset entry", 32'(rst_clk_n), 32'h0000_0000);
    endtask

    // records the edge of each stage release, counted from the reset edge
    task automatic seq_check();
        int k;
        int r_clk;
        int r_func;
        int r_cpu;
        r_clk  = -1;
        r_func = -1;
        r_cpu  = -1;
        for (k = 1; k <= SEQ_LEN + 2; k++) begin
            if (rst_clk_n === 1'b1 && r_clk < 0) r_clk = k - 1;
            if (rst_func_n === 1'b1 && r_func < 0) r_func = k - 1;
            if (rst_cpu_n === 1'b1 && r_cpu < 0) r_cpu = k - 1;
            @(posedge pclk);
        end
        check("clock stage", 32'(r_clk), CLK_STAGE);
        check("func stage", 32'(r_func), FUNC_STAGE);
        check("cpu stage", 32'(r_cpu), SEQ_LEN);
        check("debug free", 32'({rst_dbg_n, rst_cpu_dbg_n}), 32'h0000_0007);
    endtask

    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {errors, num_checks, cyc} = '0;
        rst_req = 1'b1;
        wd_req  = 3'b000;
        repeat (3) @(posedge pclk);
        rst_req <= 1'b0;
        while (presetn !== 1'b1) @(posedge pclk);
        g0 = cyc;
        seq_check();
        for (n = 0; n < 5; n++) rdc(8'(4 * n), REG_RST, "reset value");
        rdc(A_STAT, 32'h0000_188C, "status");
        apb(1'b0, 8'h18, 32'h0000_0000);
        check("unmapped", {err, rd[30:0]}, 32'h8000_0000);
        wrs(A_CTRL, 32'h0000_0008);
        check("all debug", 32'({rst_dbg_n, rst_cpu_dbg_n, rst_func_n}), 32'h0000_0001);
        wrs(A_CTRL, 32'h0000_0010);
        check("core debug", 32'({rst_dbg_n, rst_cpu_dbg_n}), 32'h0000_0006);
        wrs(A_CTRL, 32'h0000_0002);
        check("func pulse", 32'({rst_func_n, rst_cpu_n, rst_dom_n, rst_clk_n, rst_dbg_n, pll_ok}),
              32'h0000_0038);
        repeat (15) @(posedge pclk);
        check("func held", 32'(rst_func_n), 32'h0000_0000);
        @(posedge pclk);
        check("func free", 32'(rst_func_n), 32'h0000_0001);
        wrs(A_CTRL, 32'h0000_0004);
        repeat (40) @(posedge pclk);
        check("func static", 32'({rst_func_n, rst_clk_n}), 32'h0000_0001);
        wrs(A_CTRL, 32'h0000_0000);
        check("static clear", 32'(rst_func_n), 32'h0000_0001);
        wrs(A_BR, 32'h0000_0021);
        @(posedge pclk);
        check("branch", {12'h000, rst_dom_n, rst_br_n}, 32'h000F_FFDE);
        wrs(A_DOM, 32'h0000_0005);
        @(posedge pclk);
        check("domain", {12'h000, rst_dom_n, rst_br_n}, 32'h000A_F0D0);
        wrs(A_BR, 32'h0000_0000);
        wrs(A_DOM, 32'h0000_0000);
        for (n = 0; n < 4; n++) begin
            wrs(A_MODE, MODE_WR[n]);
            check("mode", 32'({axi_ratio, ddr_src, axi_src, l2_src, ddr_dither, ddr_async,
                  l2_axi_async}), MODE_EXP[n]);
        end
        while (pll_ok[0] !== 1'b1) @(posedge pclk);
        check("pll lock", 32'(cyc - g0), CLK_STAGE + LOCK_REG_CYC + 1);
        check("src wait", 32'(clk_src_ok), 32'h0000_0000);
        @(posedge pclk);
        check("src ok", 32'({clk_src_ok, pll_ok}), 32'h0000_001F);
        wd_req <= 3'b010;
        repeat (6) @(posedge pclk);
        check("core wd", 32'({rst_core_n, rst_cpu_n, rst_func_n}), 32'h0000_000B);
        wd_req <= 3'b000;
        wrs(A_WDMSK, 32'h0000_0005);
        repeat (20) @(posedge pclk);
        wd_req <= 3'b101;
        repeat (8) @(posedge pclk);
        check("masked wd", 32'({rst_core_n, rst_clk_n}), 32'h0000_0007);
        wd_req <= 3'b000;
        wrs(A_WDMSK, 32'h0000_0004);
        wd_req <= 3'b001;
        wait_low();
        wd_req <= 3'b000;
        seq_check();
        check("wd pll", 32'(pll_ok), 32'h0000_0008);
        rdc(A_MODE, REG_RST, "wd mode");
        wrs(A_MODE, MODE_WR[3]);
        apb(1'b1, A_CTRL, 32'h0000_0001);
        wait_low();
        seq_check();
        rdc(A_CTRL, REG_RST, "sw ctrl");
        rdc(A_MODE, REG_RST, "sw mode");
        rst_req <= 1'b1;
        @(posedge pclk);
        #1;
        check("async", 32'({rst_clk_n, rst_dom_n, rst_dbg_n}), 32'h0000_0000);
        end_sim();
    end
endmodule
